//--- hw/sdb_regs.vh
// Constants for the standard-architecture data bus lane steering slave
`ifndef SDB_REGS_VH
`define SDB_REGS_VH

// Bus widths
`define SDB_DATA_W 16
`define SDB_ADDR_W 24
`define SDB_LADR_W 16
`define SDB_UADR_W 8

// Bit positions in the synchronised control vector, then its width
`define SDB_CTL_ALE 0
`define SDB_CTL_RD 1
`define SDB_CTL_WR 2
`define SDB_CTL_MEMRQ 3
`define SDB_CTL_IORQ 4
`define SDB_CTL_ULE 5
`define SDB_CTL_W 6

// Idle level of the active-low controls, also their reset value
`define SDB_CTL_IDLE 6'h3f

// Byte lane codes: bit 0 is lanes D0-7, bit 1 is lanes D8-15
`define SDB_LANE_NONE 2'h0
`define SDB_LANE_LO 2'h1
`define SDB_LANE_HI 2'h2
`define SDB_LANE_BOTH 2'h3

// Reset values
`define SDB_RST_DATA 16'h0000
`define SDB_RST_UADR 8'h00
`define SDB_RST_ADDR 24'h000000

`endif

//--- hw/sdb_sync.v
// Two-flop synchroniser for a vector of backplane pins
`timescale 1ns/1ps
module sdb_sync #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Asynchronous pin levels
    input wire [W-1:0] d_i,
    // Synchronised levels
    output wire [W-1:0] q_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second; both stages reset to the RST value
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST;
            sync_q <= RST;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

//--- hw/sdb_lane_steer.v
// Slave board data bus: address latching, board select and byte lane steering
`timescale 1ns/1ps
`include "sdb_regs.vh"

// How it works
// - Upper enable low and lowest address bit low move a word, low byte D0-7, high byte D8-15.
// - Upper enable low with lowest address bit high moves one byte on lanes D8-15 only.
// - Upper enable high with lowest address bit low moves one byte on lanes D0-7 only.
// - A board that is not selected keeps its data drivers off the backplane.
// - Address bits 16-23 travel on D0-7 during the address phase, bits 0-15 on their own lines.
// - The master gives an address latch strobe and the slave uses it to hold the upper bits.
// - The upper bits are captured on the rising edge of the active-low latch strobe.
// - An 8-bit board uses only D0-7 and ignores D8-15 entirely.
// - A 16-bit board uses D0-7 and also D8-15 on the extension connector.
// - The 16 data lines are bidirectional, active high, and driven through three-state drivers.
// - With read active the selected slave drives toward the master, otherwise data flows in.
module sdb_lane_steer #(
    parameter WIDE16 = 1,
    parameter [23:0] MEM_MATCH = 24'h080000,
    parameter [23:0] MEM_MASK = 24'hff0000,
    parameter [15:0] IO_MATCH = 16'h0100,
    parameter [15:0] IO_MASK = 16'hff00
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Backplane control pins
    input wire ale_n_i,
    input wire rd_n_i,
    input wire wr_n_i,
    input wire memrq_n_i,
    input wire iorq_n_i,
    input wire upper_lane_enable_n_i,
    // Backplane address pins
    input wire [15:1] addr_i,
    input wire lowest_address_bit_i,
    // Backplane data pins, split into in, out and enables
    input wire [15:0] data_i,
    output wire [15:0] data_o,
    output wire data_lo_oe_o,
    output wire data_hi_oe_o,
    // User side: cycle information
    output wire [23:0] cyc_addr_o,
    output wire cyc_io_o,
    output wire [1:0] cyc_be_o,
    // User side: read
    output wire rd_stb_o,
    input wire [15:0] rd_data_i,
    // User side: write
    output wire wr_stb_o,
    output wire [15:0] wr_data_o
);

    wire [`SDB_CTL_W-1:0] ctl_s;
    wire [`SDB_LADR_W-1:0] adr_s;
    wire [`SDB_DATA_W-1:0] dat_raw_s;
    wire [`SDB_DATA_W-1:0] dat_s;
    wire ale_s;
    wire rd_s;
    wire wr_s;
    wire memrq_s;
    wire iorq_s;
    wire ule_s;
    wire [23:0] full_adr;
    wire mem_hit;
    wire io_hit;
    wire [1:0] lanes;
    wire sel;
    wire rd_act;
    reg ale_q;
    reg rd_q;
    reg wr_q;
    reg wr_sel_q;
    reg [15:0] dat_q;
    reg [7:0] uadr_q;
    reg [15:0] dout_q;
    reg oe_lo_q;
    reg oe_hi_q;
    reg [23:0] cyc_addr_q;
    reg cyc_io_q;
    reg [1:0] cyc_be_q;
    reg rd_stb_q;
    reg wr_stb_q;
    reg [15:0] wr_data_q;

    // Lanes used by a cycle; an 8-bit board ignores the upper enable
    function [1:0] sdb_lanes;
        input ule_n;
        input a0;
        begin
            if (WIDE16 == 0) begin
                sdb_lanes = `SDB_LANE_LO;
            end else begin
                case ({ule_n, a0})
                    2'b00: sdb_lanes = `SDB_LANE_BOTH;
                    2'b01: sdb_lanes = `SDB_LANE_HI;
                    2'b10: sdb_lanes = `SDB_LANE_LO;
                    default: sdb_lanes = `SDB_LANE_NONE;
                endcase
            end
        end
    endfunction

    // Zero the bytes of a word whose lane is not in use
    function [15:0] sdb_mask;
        input [1:0] ln;
        input [15:0] w;
        begin
            sdb_mask = {w[15:8] & {8{ln[1]}}, w[7:0] & {8{ln[0]}}};
        end
    endfunction

    // Every pin crosses two flops before any logic sees it
    sdb_sync #(
        .W(`SDB_CTL_W),
        .RST(`SDB_CTL_IDLE)
    ) u_sync_ctl (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i({upper_lane_enable_n_i, iorq_n_i, memrq_n_i, wr_n_i, rd_n_i, ale_n_i}),
        .q_o(ctl_s)
    );

    sdb_sync #(
        .W(`SDB_LADR_W),
        .RST(16'h0000)
    ) u_sync_adr (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i({addr_i, lowest_address_bit_i}),
        .q_o(adr_s)
    );

    sdb_sync #(
        .W(`SDB_DATA_W),
        .RST(`SDB_RST_DATA)
    ) u_sync_dat (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(data_i),
        .q_o(dat_raw_s)
    );

    assign ale_s = ctl_s[`SDB_CTL_ALE];
    assign rd_s = ctl_s[`SDB_CTL_RD];
    assign wr_s = ctl_s[`SDB_CTL_WR];
    assign memrq_s = ctl_s[`SDB_CTL_MEMRQ];
    assign iorq_s = ctl_s[`SDB_CTL_IORQ];
    assign ule_s = ctl_s[`SDB_CTL_ULE];

    // Upper data lines never reach the logic of an 8-bit board
    assign dat_s = (WIDE16 != 0) ? dat_raw_s : {8'h00, dat_raw_s[7:0]};

    // Memory decodes all 24 bits, I/O only the dedicated 16
    assign full_adr = {uadr_q, adr_s};
    assign mem_hit = ~memrq_s & ((full_adr & MEM_MASK) == (MEM_MATCH & MEM_MASK));
    assign io_hit = ~iorq_s & ((adr_s & IO_MASK) == (IO_MATCH & IO_MASK));
    assign lanes = sdb_lanes(ule_s, adr_s[0]);
    // Reserved lane code never selects the board
    assign sel = (mem_hit | io_hit) & (lanes != `SDB_LANE_NONE);
    // Direction comes from the master's read strobe, and only while the write strobe is high
    assign rd_act = ~rd_s & wr_s & sel;

    // Edge history and one-cycle-old data sample
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ale_q <= 1'b1;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            dat_q <= `SDB_RST_DATA;
        end else begin
            ale_q <= ale_s;
            rd_q <= rd_s;
            wr_q <= wr_s;
            dat_q <= dat_s;
        end
    end

    // Upper address held from the sample taken just before the strobe rose
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            uadr_q <= `SDB_RST_UADR;
        end else if (ale_s & ~ale_q) begin
            uadr_q <= dat_q[7:0];
        end
    end

    // Read drivers: enabled only while selected and read is low
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            oe_lo_q <= 1'b0;
            oe_hi_q <= 1'b0;
            dout_q <= `SDB_RST_DATA;
        end else begin
            oe_lo_q <= rd_act & lanes[0];
            oe_hi_q <= rd_act & lanes[1];
            dout_q <= sdb_mask(lanes, rd_data_i);
        end
    end

    // Cycle capture at the falling strobe, write strobe at its rise
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cyc_addr_q <= `SDB_RST_ADDR;
            cyc_io_q <= 1'b0;
            cyc_be_q <= `SDB_LANE_NONE;
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_sel_q <= 1'b0;
            wr_data_q <= `SDB_RST_DATA;
        end else begin
            rd_stb_q <= rd_act & rd_q;
            wr_stb_q <= 1'b0;
            if (sel & ((~rd_s & rd_q) | (~wr_s & wr_q))) begin
                cyc_addr_q <= io_hit ? {8'h00, adr_s} : full_adr;
                cyc_io_q <= io_hit;
                cyc_be_q <= lanes;
            end
            // Decide selection at the falling edge; address may move at the rise
            if (~wr_s & wr_q) begin
                wr_sel_q <= sel & rd_s;
            end else if (wr_s & ~wr_q) begin
                wr_sel_q <= 1'b0;
                wr_stb_q <= wr_sel_q;
                if (wr_sel_q) begin
                    wr_data_q <= sdb_mask(cyc_be_q, dat_q);
                end
            end
        end
    end

    assign data_o = dout_q;
    assign data_lo_oe_o = oe_lo_q;
    assign data_hi_oe_o = oe_hi_q;
    assign cyc_addr_o = cyc_addr_q;
    assign cyc_io_o = cyc_io_q;
    assign cyc_be_o = cyc_be_q;
    assign rd_stb_o = rd_stb_q;
    assign wr_stb_o = wr_stb_q;
    assign wr_data_o = wr_data_q;

endmodule

//--- verif/sdb_asserts.sv
// Port checks for the lane steering slave
`timescale 1ns/1ps
module sdb_chk (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Backplane controls
    input wire rd_n_i,
    input wire memrq_n_i,
    input wire iorq_n_i,
    // Slave outputs
    input wire data_lo_oe_o,
    input wire data_hi_oe_o,
    input wire [1:0] cyc_be_o,
    input wire cyc_io_o,
    input wire [23:0] cyc_addr_o,
    input wire rd_stb_o,
    input wire wr_stb_o,
    input wire [15:0] wr_data_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Six idle samples outlast the two-flop sync plus the output register
    sequence s_rd_off; rd_n_i [*6]; endsequence
    sequence s_unsel; (memrq_n_i && iorq_n_i) [*6]; endsequence
    a_rd_stb_pulse: assert property (rd_stb_o |=> !rd_stb_o)
        else $error("read strobe too long");
    a_wr_stb_pulse: assert property (wr_stb_o |=> !wr_stb_o)
        else $error("write strobe too long");
    a_rd_off_float: assert property (s_rd_off |-> !data_lo_oe_o && !data_hi_oe_o)
        else $error("driving without read");
    a_unsel_float: assert property (s_unsel |-> !data_lo_oe_o && !data_hi_oe_o)
        else $error("driving while unselected");
    a_hi_oe_lane: assert property (data_hi_oe_o |-> cyc_be_o[1])
        else $error("upper lane driven");
    a_lo_oe_lane: assert property (data_lo_oe_o |-> cyc_be_o[0])
        else $error("lower lane driven");
    a_wr_hi_zero: assert property (wr_stb_o && !cyc_be_o[1] |-> wr_data_o[15:8] == 8'h00)
        else $error("upper write byte not cleared");
    a_wr_lo_zero: assert property (wr_stb_o && !cyc_be_o[0] |-> wr_data_o[7:0] == 8'h00)
        else $error("lower write byte not cleared");
    a_oe_with_stb: assert property ($rose(data_lo_oe_o || data_hi_oe_o) |-> rd_stb_o)
        else $error("drive began without read strobe");
    a_io_upper_zero: assert property (cyc_io_o |-> cyc_addr_o[23:16] == 8'h00)
        else $error("I/O address has upper bits");
endmodule

//--- verif/sdb_mst_model.sv
// Backplane master model issuing memory and I/O cycles
`timescale 1ns/1ps
module sdb_mst_model (
    // Clock
    input wire mclk_i,
    // Bus pins driven by the master
    output logic ale_n_o, rd_n_o, wr_n_o, memrq_n_o, iorq_n_o, ule_n_o,
    output logic [15:0] adr_o,
    output logic [15:0] d_o,
    output logic [1:0] d_oe_o,
    // Resolved data lines
    input wire [15:0] data_i
);
    // Idle: all strobes high, data released
    initial {ale_n_o, rd_n_o, wr_n_o, memrq_n_o, iorq_n_o, ule_n_o, d_oe_o} = 8'hfc;
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Strobes held three or more cycles so the slave's sync never misses them
    task automatic cyc(input bit io, wr, ule, input [23:0] a, input [15:0] wd,
                       output [15:0] rd);
        {ule_n_o, adr_o} = {ule, a[15:0]};
        if (!io) begin
            {d_o, d_oe_o, ale_n_o} = {8'hff, a[23:16], 3'b010};
            step(3);
            {ale_n_o, d_oe_o} = 3'b100;
            step(2);
        end
        {memrq_n_o, iorq_n_o, d_o} = {io, !io, wd};
        d_oe_o = wr ? {!ule, !a[0]} : 2'b00;
        if (wr) wr_n_o = 0;
        else rd_n_o = 0;
        step(6);
        rd = data_i;
        {rd_n_o, wr_n_o} = 2'b11;
        step(1);
        {memrq_n_o, iorq_n_o, d_oe_o} = 4'hc;
        step(1);
    endtask
endmodule

//--- verif/tb_top.sv
// Bench for the lane steering slave with a backplane master model
`timescale 1ns/1ps
module tb_top;
    logic mclk_i = 0, rst_n_i = 0;
    logic [15:0] rd_data_i = 16'h0000, data_o, wr_data_o, m_d, rd, adr;
    wire [15:0] data_i;
    // Second, narrow board on the same backplane
    logic [15:0] n8_do, n8_wd, n8_rdat = 16'h0000;
    logic [23:0] n8_addr, last8 = 24'h000000;
    logic [1:0] n8_be;
    logic n8_lo_oe, n8_hi_oe, n8_io, n8_rstb, n8_wstb;
    logic [23:0] cyc_addr_o, last = 24'h000000;
    logic [1:0] cyc_be_o, m_oe;
    logic ale_n_i, rd_n_i, wr_n_i, memrq_n_i, iorq_n_i, upper_lane_enable_n_i;
    logic data_lo_oe_o, data_hi_oe_o, cyc_io_o, rd_stb_o, wr_stb_o;
    wire [15:1] addr_i = adr[15:1];
    wire lowest_address_bit_i = adr[0];
    int fail_count = 0, checked = 0, rd_seen = 0, rd8_seen = 0;
    bit [31:0] seed = 32'hf7ef5842;
    // Terminated bus: a released lane floats high
    assign data_i[15:8] = data_hi_oe_o ? data_o[15:8] : n8_hi_oe ? n8_do[15:8] :
        m_oe[1] ? m_d[15:8] : 8'hff;
    assign data_i[7:0] = data_lo_oe_o ? data_o[7:0] : n8_lo_oe ? n8_do[7:0] :
        m_oe[0] ? m_d[7:0] : 8'hff;
    initial forever #20 mclk_i = ~mclk_i;
    sdb_lane_steer #(.WIDE16(1)) dut_u(.*);
    // Narrow board in the neighbouring range keeps the 8-bit mode exercised
    sdb_lane_steer #(.WIDE16(0), .MEM_MATCH(24'h090000), .MEM_MASK(24'hff8000),
        .IO_MATCH(16'h0200), .IO_MASK(16'hff80)) dut8_u(.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .ale_n_i(ale_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .memrq_n_i(memrq_n_i),
        .iorq_n_i(iorq_n_i), .upper_lane_enable_n_i(upper_lane_enable_n_i), .addr_i(addr_i),
        .lowest_address_bit_i(lowest_address_bit_i), .data_i(data_i), .data_o(n8_do),
        .data_lo_oe_o(n8_lo_oe), .data_hi_oe_o(n8_hi_oe), .cyc_addr_o(n8_addr),
        .cyc_io_o(n8_io), .cyc_be_o(n8_be), .rd_stb_o(n8_rstb), .rd_data_i(n8_rdat),
        .wr_stb_o(n8_wstb), .wr_data_o(n8_wd));
    // Read strobes counted mid-cycle, where the registered pulse stands
    always @(negedge mclk_i) begin
        rd_seen += rd_stb_o;
        rd8_seen += n8_rstb;
    end
    sdb_mst_model m_u(.mclk_i(mclk_i), .ale_n_o(ale_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i),
        .memrq_n_o(memrq_n_i), .iorq_n_o(iorq_n_i), .ule_n_o(upper_lane_enable_n_i),
        .adr_o(adr), .d_o(m_d), .d_oe_o(m_oe), .data_i(data_i));
    function automatic bit [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input [23:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One cycle against the reference: lanes from the upper enable and bit 0
    task automatic run(input bit io, wr, ule, input [23:0] a);
        logic [15:0] wd, ew;
        logic [1:0] be, be8;
        int n, r0, r8;
        wd = xs();
        rd_data_i = xs();
        n8_rdat = xs();
        be = (ule && a[0]) ? 2'b00 : {!ule, !a[0]};
        if (io ? a[15:8] != 8'h01 : a[23:16] != 8'h08) be = 2'b00;
        // Narrow board: its own range, low lanes only, upper enable ignored
        be8 = (io ? a[15:7] == {8'h02, 1'b0} : a[23:15] == {8'h09, 1'b0}) ? 2'b01 : 2'b00;
        r0 = rd_seen;
        r8 = rd8_seen;
        m_u.cyc(io, wr, ule, a, wd, rd);
        n = 0;
        if (wr) begin
            while (!(wr_stb_o || n8_wstb) && n < 8) begin
                @(posedge mclk_i);
                #1;
                n++;
            end
            chk({wr_stb_o, n8_wstb}, {be != 2'b00, be8 != 2'b00});
            ew = {be[1] ? wd[15:8] : 8'h00, be[0] ? wd[7:0] : 8'h00};
            if (be != 2'b00) chk(wr_data_o, ew);
            // Low lane is driven only when bit 0 is clear; otherwise the pull-ups show
            if (be8 != 2'b00) chk(n8_wd, {8'h00, a[0] ? 8'hff : wd[7:0]});
        end else begin
            ew = {be[1] ? rd_data_i[15:8] : 8'hff, be[0] ? rd_data_i[7:0] : 8'hff};
            if (be8 != 2'b00) ew[7:0] = n8_rdat[7:0];
            chk(rd, ew);
            chk(rd_seen - r0, be != 2'b00);
            chk(rd8_seen - r8, be8 != 2'b00);
        end
        if (be != 2'b00) last = io ? {8'h00, a[15:0]} : a;
        if (be8 != 2'b00) last8 = io ? {8'h00, a[15:0]} : a;
        chk(cyc_addr_o, last);
        chk(n8_addr, last8);
        if (be != 2'b00) chk({cyc_io_o, cyc_be_o}, {io, be});
        if (be8 != 2'b00) chk({n8_io, n8_be}, {io, be8});
        repeat (4) @(posedge mclk_i);
        #1;
    endtask
    // Random mix of kinds, lanes, hits, misses and the reserved code
    initial begin
        bit [31:0] r;
        logic [23:0] a;
        repeat (4) @(posedge mclk_i);
        #1 rst_n_i = 1;
        chk({data_lo_oe_o, data_hi_oe_o, n8_lo_oe, n8_hi_oe}, 4'h0);
        for (int i = 0; i < 80; i++) begin
            r = xs();
            a = {(r[4] | r[6]) ? 8'h08 : 8'h09, r[15:8], r[23:17], r[3]};
            if (r[0]) a[15:8] = (r[4] | r[6]) ? 8'h01 : 8'h02;
            run(r[0], r[1], r[2] & !(r[3] & r[5]), a);
        end
        results();
    end
    // Watchdog
    initial begin
        repeat (6000) @(posedge mclk_i);
        fail_count++;
        results();
    end
endmodule
bind sdb_lane_steer sdb_chk chk_u(.*);
